// file: core/gear_tooth_pkg.sv
// Purpose: shared constants for the dual channel gear tooth decision logic
// Assumes: 40 MHz system clock, 12-bit flux samples from an outside converter
// Notes:   sample tick near 500 kHz, fault shutdown inside 10..20 us
package gear_tooth_pkg;
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned SAMPLE_HZ         = 500_000;
    localparam int unsigned TICK_DIV          = CLK_HZ / SAMPLE_HZ;
    localparam int          TICK_W            = 7;
    localparam int          FLUX_W            = 12;
    localparam logic [11:0] HYST_CODE         = 12'h014;
    // fault shutdown time in ns; 15 us sits mid-interval
    localparam int unsigned FAULT_MIN_NS      = 10_000;
    localparam int unsigned FAULT_MAX_NS      = 20_000;
    localparam int unsigned FAULT_TARGET_NS   = 15_000;
    localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
    localparam int unsigned FAULT_CYCLES      = FAULT_TARGET_NS / CLK_PERIOD_NS;
    localparam int unsigned FAULT_MIN_CYCLES  = FAULT_MIN_NS / CLK_PERIOD_NS;
    localparam int unsigned FAULT_MAX_CYCLES  = FAULT_MAX_NS / CLK_PERIOD_NS;
    localparam int          FAULT_W           = 10;
    localparam logic        OUT_RESET_LEVEL   = 1'b1;
endpackage : gear_tooth_pkg

// file: core/flux_channel.sv
// Purpose: one channel of peak and valley tracking with hysteresis switching
// Assumes: flux_in valid at every sample_tick
// Notes:   output level 1 means released (off), 0 means pulled low (on)
`timescale 1ns/100ps
module flux_channel (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        sample_tick,
    input  wire logic [11:0] flux_in,
    output logic             level_q,
    output logic             rising_q,
    output logic             armed_q
);
    logic [11:0] extreme_q;
    logic [12:0] up_span;
    logic [12:0] down_span;
    wire         above   = flux_in > extreme_q;
    wire         below   = flux_in < extreme_q;
    assign up_span   = {1'b0, flux_in} - {1'b0, extreme_q};
    assign down_span = {1'b0, extreme_q} - {1'b0, flux_in};
    // turn-back by hysteresis from a peak or a valley
    wire         turn_dn = rising_q & below & (down_span >= {1'b0, gear_tooth_pkg::HYST_CODE});
    wire         turn_up = ~rising_q & above & (up_span >= {1'b0, gear_tooth_pkg::HYST_CODE});

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            extreme_q <= 12'h000;
            rising_q  <= 1'b1;
            armed_q   <= 1'b0;
            level_q   <= gear_tooth_pkg::OUT_RESET_LEVEL;
        end else if (sample_tick) begin
            if (turn_dn) begin
                rising_q  <= 1'b0;
                extreme_q <= flux_in;
                if (armed_q) begin
                    level_q <= 1'b0;
                end
            end else if (turn_up) begin
                rising_q  <= 1'b1;
                extreme_q <= flux_in;
                armed_q   <= 1'b1;
                level_q   <= 1'b1;
            end else if ((rising_q & above) | (~rising_q & below)) begin
                extreme_q <= flux_in;
            end
        end
    end
endmodule : flux_channel

// file: core/gear_tooth_detector.sv
// Purpose: dual channel gear tooth detector decision logic with open-drain outputs
// Assumes: flux samples synchronous to clk; output short sensed by an outside comparator
// Notes:   thresholds follow the signal itself, so no trim input exists
//
// Notes on behaviour
// - Each sample classifies each channel trend as rising or falling and keeps its extreme.
// - Channel one turns on after a peak once flux falls by the hysteresis amount.
// - Channel one turns off after a valley once flux rises by the hysteresis amount.
// - Channel two behaves the same from its own sensing element.
// - After reset both outputs are high and carry no field information.
// - Each output holds until its channel has seen a first valley.
// - A shorted output is shut down within 10 to 20 us.
// - Thresholds self-adapt over the whole back-bias range with no trimming.
`timescale 1ns/100ps
module gear_tooth_detector (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [11:0] flux_one,
    input  wire logic [11:0] flux_two,
    input  wire logic        short_one,
    input  wire logic        short_two,
    input  wire logic        channel_one_out_i,
    output logic             channel_one_out_o,
    output logic             channel_one_out_oe,
    input  wire logic        channel_two_out_i,
    output logic             channel_two_out_o,
    output logic             channel_two_out_oe,
    output logic             fault_one_q,
    output logic             fault_two_q
);
    logic [6:0] tick_cnt_q;
    logic       tick;
    logic [1:0] level;
    logic [1:0] rising;
    logic [1:0] armed;
    logic [1:0] short_in;
    logic [1:0] fault_q;
    logic [9:0] fault_cnt_q [2];
    wire  [11:0] flux [2];

    assign flux[0]  = flux_one;
    assign flux[1]  = flux_two;
    assign short_in = {short_two, short_one};

    // single clock: sample rate is an enable pulse
    assign tick = (tick_cnt_q == 7'(gear_tooth_pkg::TICK_DIV - 1));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick ? 7'h00 : tick_cnt_q + 7'h01;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // same channel logic twice, shared hysteresis
            flux_channel u_ch (
                .clk         (clk),
                .reset_n     (reset_n),
                .sample_tick (tick),
                .flux_in     (flux[g]),
                .level_q     (level[g]),
                .rising_q    (rising[g]),
                .armed_q     (armed[g])
            );
            // short must persist the full window; latched until reset
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    fault_cnt_q[g] <= 10'h000;
                    fault_q[g]     <= 1'b0;
                end else if (!fault_q[g]) begin
                    if (!short_in[g]) begin
                        fault_cnt_q[g] <= 10'h000;
                    end else if (fault_cnt_q[g] == 10'(gear_tooth_pkg::FAULT_CYCLES - 1)) begin
                        fault_q[g] <= 1'b1;
                    end else begin
                        fault_cnt_q[g] <= fault_cnt_q[g] + 10'h001;
                    end
                end
            end
        end
    endgenerate

    // open drain: drive low only when on and not faulted
    assign channel_one_out_o  = 1'b0;
    assign channel_two_out_o  = 1'b0;
    assign channel_one_out_oe = ~level[0] & ~fault_q[0];
    assign channel_two_out_oe = ~level[1] & ~fault_q[1];
    assign fault_one_q        = fault_q[0];
    assign fault_two_q        = fault_q[1];

    // assertions
    int unsigned short_run_q;
    int unsigned short_run_two_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            short_run_q     <= 0;
            short_run_two_q <= 0;
        end else begin
            short_run_q     <= short_one ? short_run_q + 1 : 0;
            short_run_two_q <= short_two ? short_run_two_q + 1 : 0;
        end
    end

    // tick spacing counted apart from the divider
    logic [7:0] since_tick_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_tick_q <= 8'h00;
        end else begin
            since_tick_q <= tick ? 8'h00 : since_tick_q + 8'h01;
        end
    end

    property p_tick_period;
        @(posedge clk) disable iff (!reset_n)
        tick |=> !tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick too frequent");

    property p_reset_high;
        @(posedge clk) $rose(reset_n) |-> !channel_one_out_oe && !channel_two_out_oe;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("output low after reset");

    property p_hold_until_armed;
        @(posedge clk) disable iff (!reset_n)
        !armed[0] |-> level[0];
    endproperty
    a_hold_until_armed: assert property (p_hold_until_armed) else $error("switch before valley");

    property p_on_after_peak;
        @(posedge clk) disable iff (!reset_n)
        $fell(level[0]) |-> $fell(rising[0]) && armed[0];
    endproperty
    a_on_after_peak: assert property (p_on_after_peak) else $error("on without peak");

    property p_off_after_valley;
        @(posedge clk) disable iff (!reset_n)
        $rose(level[0]) |-> $rose(rising[0]);
    endproperty
    a_off_after_valley: assert property (p_off_after_valley) else $error("off without valley");

    property p_ch2_same;
        @(posedge clk) disable iff (!reset_n)
        $fell(level[1]) |-> $fell(rising[1]) && armed[1];
    endproperty
    a_ch2_same: assert property (p_ch2_same) else $error("channel two on without peak");

    property p_fault_min;
        @(posedge clk) disable iff (!reset_n)
        $rose(fault_one_q) |-> short_run_q >= gear_tooth_pkg::FAULT_MIN_CYCLES;
    endproperty
    a_fault_min: assert property (p_fault_min) else $error("shutdown too early");

    property p_fault_max;
        @(posedge clk) disable iff (!reset_n)
        short_run_q == gear_tooth_pkg::FAULT_MAX_CYCLES |-> fault_one_q && !channel_one_out_oe;
    endproperty
    a_fault_max: assert property (p_fault_max) else $error("shutdown too late");

    property p_tick_change_only;
        @(posedge clk) disable iff (!reset_n)
        !$past(tick) |-> $stable(level);
    endproperty
    a_tick_change_only: assert property (p_tick_change_only) else $error("change off tick");

    property p_ch2_hold_until_armed;
        @(posedge clk) disable iff (!reset_n)
        !armed[1] |-> level[1];
    endproperty
    a_ch2_hold_until_armed: assert property (p_ch2_hold_until_armed) else $error("two early");

    property p_ch2_off_after_valley;
        @(posedge clk) disable iff (!reset_n)
        $rose(level[1]) |-> $rose(rising[1]);
    endproperty
    a_ch2_off_after_valley: assert property (p_ch2_off_after_valley) else $error("two off");

    property p_fault_two_min;
        @(posedge clk) disable iff (!reset_n)
        $rose(fault_two_q) |-> short_run_two_q >= gear_tooth_pkg::FAULT_MIN_CYCLES;
    endproperty
    a_fault_two_min: assert property (p_fault_two_min) else $error("two shutdown early");

    property p_fault_two_max;
        @(posedge clk) disable iff (!reset_n)
        short_run_two_q == gear_tooth_pkg::FAULT_MAX_CYCLES |-> fault_two_q && !channel_two_out_oe;
    endproperty
    a_fault_two_max: assert property (p_fault_two_max) else $error("two shutdown late");

    // shutdown is held; a recovering short must not re-enable the pin
    property p_fault_sticky;
        @(posedge clk) disable iff (!reset_n)
        !$fell(fault_one_q) && !$fell(fault_two_q);
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault released");

    property p_fault_off;
        @(posedge clk) disable iff (!reset_n)
        (!fault_one_q || !channel_one_out_oe) && (!fault_two_q || !channel_two_out_oe);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("faulted pin driven");

    property p_rising_on_tick;
        @(posedge clk) disable iff (!reset_n)
        !$past(tick) |-> $stable(rising) && $stable(armed);
    endproperty
    a_rising_on_tick: assert property (p_rising_on_tick) else $error("trend off tick");

    property p_tick_spacing;
        @(posedge clk) disable iff (!reset_n)
        tick |-> since_tick_q == 8'(gear_tooth_pkg::TICK_DIV - 1);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick period wrong");

    c_on:     cover property (@(posedge clk) disable iff (!reset_n) $fell(level[0]));
    c_off:    cover property (@(posedge clk) disable iff (!reset_n) $rose(level[0]) && armed[0]);
    c_fault:  cover property (@(posedge clk) disable iff (!reset_n) $rose(fault_two_q));
    c_both:   cover property (@(posedge clk) disable iff (!reset_n) !level[0] && !level[1]);
    c_fault1: cover property (@(posedge clk) disable iff (!reset_n) $rose(fault_one_q));
endmodule : gear_tooth_detector

// file: tb/pullup_controller.sv
// Purpose: controller side of both open-drain outputs, with pull-ups
// Assumes: oe high pulls a pin low, released pins float up
// Notes:   direction latched as channel two level at each channel one rise
`timescale 1ns/100ps
module pullup_controller (
    input  wire logic clk,
    input  wire logic one_oe,
    input  wire logic two_oe,
    output logic      one_pin,
    output logic      two_pin,
    output logic      dir_q
);
    logic one_last_q;
    // pull-up wins whenever the pin is released
    assign one_pin = one_oe ? 1'b0 : 1'b1;
    assign two_pin = two_oe ? 1'b0 : 1'b1;
    always_ff @(posedge clk) begin
        one_last_q <= one_pin;
        if (one_pin && !one_last_q) dir_q <= two_pin;
    end
endmodule : pullup_controller

// file: tb/test_gear_tooth_detector.sv
// Purpose: self-checking bench for the dual channel decision logic
// Assumes: every flux value held 80 cycles, so one tick samples it
// Notes:   channel two gets random codes, channel one a fixed wave
`timescale 1ns/100ps
module test_gear_tooth_detector;
    localparam int          HYST = gear_tooth_pkg::HYST_CODE;
    localparam logic [11:0] WAVE [10] = '{12'h064, 12'h0c8, 12'h0b5, 12'h0b4, 12'h0a0,
                                          12'h0b3, 12'h0b4, 12'h12c, 12'h118, 12'h064};
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] flux_one = 12'h000;
    logic [11:0] flux_two = 12'h000;
    logic        short_one = 1'b0;
    logic        short_two = 1'b0;
    logic        dir_q;
    logic        dir_exp = 1'b0;
    logic        one_oe, two_oe, one_pin, two_pin, fault_one_q, fault_two_q, watch;
    logic [1:0]  oe_now;
    logic        q_one[$], q_two[$];
    logic        rising[2] = '{1'b1, 1'b1};
    logic        armed[2] = '{1'b0, 1'b0};
    logic        oe_m[2] = '{1'b0, 1'b0};
    logic        seen[2] = '{1'b0, 1'b0};
    int          ext[2] = '{0, 0};
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    integer      seed = 32'h05cf;
    logic [31:0] r;

    gear_tooth_detector i_gear_tooth_detector (.clk(clk), .reset_n(reset_n),
        .flux_one(flux_one), .flux_two(flux_two), .short_one(short_one), .short_two(short_two),
        .channel_one_out_i(one_pin), .channel_one_out_o(), .channel_one_out_oe(one_oe),
        .channel_two_out_i(two_pin), .channel_two_out_o(), .channel_two_out_oe(two_oe),
        .fault_one_q(fault_one_q), .fault_two_q(fault_two_q));
    pullup_controller i_pullup_controller (.clk(clk), .one_oe(one_oe), .two_oe(two_oe),
        .one_pin(one_pin), .two_pin(two_pin), .dir_q(dir_q));

    always #12.5 clk = ~clk;

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check

    task automatic push(input int c, input logic v);
        if (oe_m[c] != v) begin
            oe_m[c] = v;
            if (c == 0) q_one.push_back(v);
            else q_two.push_back(v);
        end
    endtask : push

    // reference tracker, threshold equality counts as reached
    task automatic model(input int c, input int x);
        if (rising[c]) begin
            if (x > ext[c]) ext[c] = x;
            else if (x + HYST <= ext[c]) begin
                rising[c] = 1'b0;
                ext[c] = x;
                if (armed[c]) push(c, 1'b1);
            end
        end else begin
            if (x < ext[c]) ext[c] = x;
            else if (x >= ext[c] + HYST) begin
                rising[c] = 1'b1;
                ext[c] = x;
                armed[c] = 1'b1;
                push(c, 1'b0);
            end
        end
    endtask : model

    task automatic sample(input logic [11:0] a, input logic [11:0] b);
        flux_one <= a;
        flux_two <= b;
        model(0, a);
        model(1, b);
        repeat (80) @(posedge clk);
    endtask : sample

    function automatic logic pop(input int c, input logic now);
        if (c == 0) return q_one.size() > 0 ? q_one.pop_front() : ~now;
        return q_two.size() > 0 ? q_two.pop_front() : ~now;
    endfunction : pop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    // empty queue yields a forced mismatch, so stray switching is caught
    always @(negedge clk) begin
        oe_now = {two_oe, one_oe};
        for (int c = 0; c < 2; c++) begin
            if (watch && oe_now[c] !== seen[c]) begin
                check("oe", oe_now[c], pop(c, oe_now[c]));
                if (c == 0 && !oe_now[0]) dir_exp = ~oe_m[1];
                seen[c] = oe_now[c];
            end
        end
    end

    initial begin
        watch = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("one_oe", one_oe, 1'b0);
        check("two_oe", two_oe, 1'b0);
        watch = 1'b1;
        @(posedge clk);
        for (int i = 0; i < 120; i++) begin
            r = $random(seed);
            sample(WAVE[i % 10], r[11:0]);
        end
        repeat (100) @(posedge clk);
        check("one_left", q_one.size() == 0, 1'b1);
        check("two_left", q_two.size() == 0, 1'b1);
        check("dir", dir_q, dir_exp);
        watch = 1'b0;
        short_one <= 1'b1;
        repeat (399) @(posedge clk);
        @(negedge clk);
        check("fault_early", fault_one_q, 1'b0);
        repeat (402) @(posedge clk);
        @(negedge clk);
        check("fault_late", fault_one_q, 1'b1);
        check("one_oe_off", one_oe, 1'b0);
        check("fault_two", fault_two_q, 1'b0);
        // a one-cycle gap must restart the shutdown count
        @(posedge clk);
        short_two <= 1'b1;
        repeat (500) @(posedge clk);
        short_two <= 1'b0;
        @(posedge clk);
        short_two <= 1'b1;
        repeat (599) @(posedge clk);
        @(negedge clk);
        check("fault_two_gap", fault_two_q, 1'b0);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("fault_two_late", fault_two_q, 1'b1);
        check("two_oe_off", two_oe, 1'b0);
        check("fault_one_held", fault_one_q, 1'b1);
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        check("fault_reset", fault_one_q, 1'b0);
        check("fault_two_reset", fault_two_q, 1'b0);
        finish_test();
    end
endmodule : test_gear_tooth_detector
